/* iam_mapper.sv */
// indirect address mapper: pointer registers and indirect port redirection
// ==========================================================
// Summary of operation
// - the indirect ports store nothing; each access goes to the location the pointer selects
// - a pointer aimed at an indirect port reads zero and writes nothing
// - each pointer is its high byte and low byte joined into 16 bits
// - pointer 0x2000 to 0x29af is a linear window over the ram blocks of banks 0 to 30
// - unimplemented locations reached through the window read 0x00
// - the window runs straight from one bank's last ram byte to the next bank's first
// - the 16 shared common bytes never appear in the window
// - with the pointer msb set the low 15 bits address a program flash word
// - flash reads through the port return the low 8 bits of the word
// - writes through the port never change flash
// - a flash access through the port takes one extra instruction cycle
// - each bank's general purpose ram block is 80 bytes
// - ports and pointer bytes sit at the same low offsets in every bank, port 0 at 000h
`timescale 1ns/10ps
module iam_mapper
  import iam_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [iam_pkg::DADDR_W-1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_ack,
  output logic mem_req,
  output logic mem_we,
  output logic [iam_pkg::DADDR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_impl,
  output logic flash_req,
  output logic [iam_pkg::FADDR_W-1:0] flash_addr,
  input wire logic [13:0] flash_rdata
);
  import iam_pkg::*;
  // ==========================================================
  // pointer registers
  logic [7:0] ptr_lo [2];
  logic [7:0] ptr_hi [2];
  logic [7:0] next_ptr_lo [2];
  logic [7:0] next_ptr_hi [2];
  logic [6:0] ofs;
  logic is_port;
  logic sel;
  logic [15:0] ptr;
  iam_region_e region;
  logic [DADDR_W-1:0] daddr;
  logic [FADDR_W-1:0] faddr;
  logic self_ref;
  logic ptr_hit;
  logic [6:0] wofs;
  logic flash_wait;
  logic next_flash_wait;
  assign ofs = cpu_addr[6:0];
  assign is_port = (ofs == PORT0_OFS) || (ofs == PORT1_OFS);
  assign sel = (ofs == PORT1_OFS);
  assign ptr = {ptr_hi[sel], ptr_lo[sel]};
  // a port write that lands on a pointer byte reloads that pointer too
  assign wofs = mem_addr[6:0];
  assign ptr_hit = mem_req && mem_we && wofs >= PTR0_LO_OFS && wofs <= PTR1_HI_OFS;
  iam_decode iam_decode_inst (
    .ptr(ptr),
    .region(region),
    .daddr(daddr),
    .faddr(faddr),
    .self_ref(self_ref)
  );
  always_comb
  begin
    next_ptr_lo = ptr_lo;
    next_ptr_hi = ptr_hi;
    // pointer bytes also go on to memory, so a direct read returns them
    if (ptr_hit)
    begin
      unique case (wofs)
        PTR0_LO_OFS: next_ptr_lo[0] = cpu_wdata;
        PTR0_HI_OFS: next_ptr_hi[0] = cpu_wdata;
        PTR1_LO_OFS: next_ptr_lo[1] = cpu_wdata;
        default: next_ptr_hi[1] = cpu_wdata;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ptr_lo <= '{PTR_RST, PTR_RST};
      ptr_hi <= '{PTR_RST, PTR_RST};
    end
    else
    begin
      ptr_lo <= next_ptr_lo;
      ptr_hi <= next_ptr_hi;
    end
  end
  // ==========================================================
  // flash stall: the first cycle requests, the second answers
  always_comb
  begin
    next_flash_wait = 1'b0;
    if (cpu_req && is_port && region == IAM_FLASH && !flash_wait)
    begin
      next_flash_wait = 1'b1;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      flash_wait <= 1'b0;
    end
    else
    begin
      flash_wait <= next_flash_wait;
    end
  end
  // ==========================================================
  // redirection; port accesses never touch storage of their own
  always_comb
  begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_addr = cpu_addr;
    mem_wdata = cpu_wdata;
    flash_req = 1'b0;
    flash_addr = faddr;
    cpu_rdata = mem_rdata;
    cpu_ack = cpu_req;
    if (cpu_req && is_port)
    begin
      mem_addr = daddr;
      unique case (region)
        IAM_FLASH:
        begin
          flash_req = 1'b1;
          cpu_ack = flash_wait;
          cpu_rdata = flash_rdata[7:0];
        end
        IAM_VOID:
        begin
          cpu_rdata = READ_ZERO;
        end
        default:
        begin
          if (self_ref)
          begin
            cpu_rdata = READ_ZERO;
          end
          else
          begin
            mem_req = 1'b1;
            mem_we = cpu_we;
            // memory may leave its holes undriven, so they are zeroed here
            cpu_rdata = mem_impl ? mem_rdata : READ_ZERO;
          end
        end
      endcase
    end
    else if (cpu_req)
    begin
      mem_req = 1'b1;
      mem_we = cpu_we;
    end
  end
  // ==========================================================
  // checks
  flash_stall_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && is_port && region == IAM_FLASH && !flash_wait |-> !cpu_ack ##1 flash_wait)
    else $error("flash access not stalled one cycle");
  flash_ack_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && is_port && region == IAM_FLASH && flash_wait |-> cpu_ack)
    else $error("flash access not answered in its second cycle");
  self_zero_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && is_port && self_ref && region != IAM_FLASH |-> cpu_rdata == 8'h00 && !mem_req)
    else $error("self reference not zeroed");
  flash_nowrite_a: assert property (@(posedge mclk) disable iff (reset)
    flash_req |-> !mem_we)
    else $error("flash access wrote memory");
  flash_low_a: assert property (@(posedge mclk) disable iff (reset)
    flash_req && cpu_ack |-> cpu_rdata == flash_rdata[7:0] && flash_addr == ptr[14:0])
    else $error("flash read data wrong");
  ptr_write_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && cpu_we && ofs == PTR0_HI_OFS |=> ptr_hi[0] == $past(cpu_wdata))
    else $error("pointer high byte not loaded");
  ind_ptr_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && cpu_we && is_port && mem_req && daddr[6:0] == PTR1_LO_OFS
    |=> ptr_lo[1] == $past(cpu_wdata))
    else $error("port write to pointer byte lost");
  direct_pass_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && !is_port |-> mem_req && cpu_ack && mem_addr == cpu_addr)
    else $error("direct access not passed to memory");
  lin_first_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && is_port && ptr == 16'h2050 |-> mem_addr == 12'h0a0)
    else $error("window not continuous across banks");
  lin_base_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && is_port && ptr == 16'h2000 |-> mem_addr == 12'h020 && mem_req)
    else $error("window base misplaced");
  lin_last_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && is_port && ptr == 16'h29af |-> mem_addr == 12'hf6f && mem_req)
    else $error("window end misplaced");
  trad_map_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && is_port && region == IAM_TRAD && !self_ref |-> mem_req && mem_addr == ptr[11:0])
    else $error("direct region not mapped");
  void_zero_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && is_port && ptr == 16'h29b0 |-> cpu_rdata == 8'h00 && !mem_req)
    else $error("gap region not zero");
  void_nowrite_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && is_port && region == IAM_VOID |-> !mem_req && !mem_we)
    else $error("gap region reached memory");
  unimpl_zero_a: assert property (@(posedge mclk) disable iff (reset)
    mem_req && !mem_impl && is_port && !cpu_we |-> cpu_rdata == 8'h00)
    else $error("unimplemented read not zero");
  // cover points for the main access kinds
  cov_flash_c: cover property (@(posedge mclk) flash_req ##1 cpu_ack);
  cov_lin_c: cover property (@(posedge mclk) mem_req && is_port && region == IAM_LIN);
  cov_self_c: cover property (@(posedge mclk) cpu_req && self_ref);
  cov_void_c: cover property (@(posedge mclk) cpu_req && is_port && region == IAM_VOID);
endmodule // iam_mapper

/* iam_pkg.sv */
// shared constants for the indirect address mapper
package iam_pkg;
  // ==========================================================
  // pointer regions
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_LAST = 16'h29af;
  localparam logic [6:0] GPR_BYTES = 7'h50;
  localparam logic [6:0] GPR_START = 7'h20;
  localparam int BANK_SPAN = 128;
  // ==========================================================
  // register offsets within a bank
  localparam logic [6:0] PORT0_OFS = 7'h00;
  localparam logic [6:0] PORT1_OFS = 7'h01;
  localparam logic [6:0] PTR0_LO_OFS = 7'h04;
  localparam logic [6:0] PTR0_HI_OFS = 7'h05;
  localparam logic [6:0] PTR1_LO_OFS = 7'h06;
  localparam logic [6:0] PTR1_HI_OFS = 7'h07;
  // ==========================================================
  // widths and reset values
  localparam int DADDR_W = 12;
  localparam int FADDR_W = 15;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int FLASH_EXTRA_CYC = 1;
  typedef enum logic [1:0] {IAM_TRAD, IAM_LIN, IAM_FLASH, IAM_VOID} iam_region_e;
endpackage

/* iam_decode.sv */
// pointer-to-target decoder for the indirect data port
`timescale 1ns/10ps
module iam_decode
  import iam_pkg::*;
(
  input wire logic [15:0] ptr,
  output iam_pkg::iam_region_e region,
  output logic [iam_pkg::DADDR_W-1:0] daddr,
  output logic [iam_pkg::FADDR_W-1:0] faddr,
  output logic self_ref
);
  import iam_pkg::*;
  logic [15:0] ofs;
  logic [15:0] bank;
  logic [15:0] rem;
  logic [15:0] tgt;
  always_comb
  begin
    ofs = ptr - LIN_BASE;
    bank = ofs / {9'h000, GPR_BYTES};
    rem = ofs % {9'h000, GPR_BYTES};
    tgt = 16'(bank * 16'(BANK_SPAN)) + {9'h000, GPR_START} + rem;
    faddr = ptr[FADDR_W-1:0];
    daddr = ptr[DADDR_W-1:0];
    region = IAM_VOID;
    if (ptr[15])
    begin
      region = IAM_FLASH;
    end
    else if (ptr >= LIN_BASE && ptr <= LIN_LAST)
    begin
      region = IAM_LIN;
      daddr = tgt[DADDR_W-1:0];
    end
    else if (ptr < LIN_BASE)
    begin
      region = IAM_TRAD;
    end
    self_ref = (region != IAM_FLASH) && (region != IAM_VOID)
      && (daddr[6:0] == PORT0_OFS || daddr[6:0] == PORT1_OFS);
  end
endmodule // iam_decode

/* iam_mem_model.sv */
// data memory and program flash stand-in for the mapper's far side
`timescale 1ns/10ps
module iam_mem_model
  import iam_pkg::*;
(
  input wire logic mclk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [iam_pkg::DADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_impl,
  input wire logic flash_req,
  input wire logic [iam_pkg::FADDR_W-1:0] flash_addr,
  output logic [13:0] flash_rdata
);
  logic [7:0] ram [0:4095];
  logic [7:0] junk = 8'ha5;
  // only banks 0..2 hold ram, so the upper window is unimplemented
  assign mem_impl = mem_addr < 12'h180;
  // idle lines keep changing so a stale value never passes as an answer
  assign mem_rdata = (mem_req && mem_impl) ? ram[mem_addr] : junk;
  assign flash_rdata = flash_req ? (flash_addr[13:0] ^ 14'h2a5a) : {6'h3f, junk};
  always @(posedge mclk)
  begin
    junk <= {junk[6:0], junk[7]};
    if (mem_req && mem_we && mem_impl)
      ram[mem_addr] <= mem_wdata;
  end
endmodule // iam_mem_model

/* iam_mapper_tb.sv */
// self-checking bench for the indirect address mapper
`timescale 1ns/10ps
module iam_mapper_tb;
  import iam_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  logic [11:0] cpu_addr = 12'h000;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata, mem_rdata, mem_wdata, rd;
  logic cpu_ack, mem_req, mem_we, mem_impl, flash_req, mq;
  logic [11:0] mem_addr;
  logic [14:0] flash_addr;
  logic [13:0] flash_rdata;
  int cyc;
  int fails = 0;
  int comparisons = 0;
  iam_mapper iam_mapper_inst (.mclk(mclk), .reset(reset), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_ack(cpu_ack), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_impl(mem_impl),
    .flash_req(flash_req), .flash_addr(flash_addr), .flash_rdata(flash_rdata));
  iam_mem_model iam_mem_model_inst (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_impl(mem_impl), .flash_req(flash_req), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata));
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // one core access, held until acknowledged or for at most 4 cycles; inputs move on falling edges
  task automatic acc(input logic we, input logic [11:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    cyc = 0;
    mq = 1'b0;
    @(negedge mclk);
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = d;
    repeat (4)
    begin
      if (!done)
      begin
        cyc++;
        // look once the combinational answer has settled, well before the edge
        #1;
        mq = mq | (mem_req === 1'b1);
        rd = cpu_rdata;
        done = (cpu_ack === 1'b1);
        @(negedge mclk);
      end
    end
    cpu_req = 1'b0;
    chk(16'(done), 16'h0001);
  endtask
  task automatic setp(input logic [11:0] base, input logic [15:0] v);
    acc(1'b1, base, v[7:0]);
    acc(1'b1, base + 12'h001, v[15:8]);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_linear;
    setp(12'h004, 16'h204f);
    acc(1'b1, 12'h000, 8'ha5);
    setp(12'h184, 16'h2050);
    acc(1'b1, 12'h100, 8'h3c);
    chk(16'(cyc), 16'h0001);
    acc(1'b0, 12'h06f, 8'h00);
    chk(rd, 8'ha5);
    acc(1'b0, 12'h0a0, 8'h00);
    chk(rd, 8'h3c);
    acc(1'b0, 12'h080, 8'h00);
    chk(rd, 8'h3c);
    setp(12'h086, 16'h00a0);
    acc(1'b0, 12'h281, 8'h00);
    chk(rd, 8'h3c);
    // a port write landing on a pointer byte must reload that pointer
    acc(1'b1, 12'h055, 8'h9c);
    setp(12'h004, 16'h0006);
    acc(1'b1, 12'h000, 8'h55);
    acc(1'b0, 12'h001, 8'h00);
    chk(rd, 8'h9c);
    $display("linear test done");
  endtask
  task automatic t_refuse;
    setp(12'h004, 16'h0081);
    acc(1'b1, 12'h000, 8'h77);
    chk(mq, 1'b0);
    acc(1'b0, 12'h000, 8'h00);
    chk(rd, 8'h00);
    setp(12'h004, 16'h29b0);
    acc(1'b0, 12'h000, 8'h00);
    chk(rd, 8'h00);
    chk(mq, 1'b0);
    setp(12'h004, 16'h20f0);
    acc(1'b0, 12'h000, 8'h00);
    chk(rd, 8'h00);
    setp(12'h004, 16'h29af);
    acc(1'b0, 12'h000, 8'h00);
    chk(rd, 8'h00);
    chk(mq, 1'b1);
    $display("refusal test done");
  endtask
  task automatic t_flash;
    setp(12'h006, 16'h8123);
    acc(1'b0, 12'h001, 8'h00);
    chk(rd, 8'h23 ^ 8'h5a);
    chk(16'(cyc), 16'h0002);
    acc(1'b1, 12'h001, 8'hff);
    chk(mq, 1'b0);
    acc(1'b0, 12'h001, 8'h00);
    chk(rd, 8'h79);
    $display("flash test done");
  endtask
  // ==========================================================
  // run control
  task automatic give_verdict;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    t_linear();
    t_refuse();
    t_flash();
    give_verdict();
  end
  // about 35 accesses of 2 to 3 cycles each; ample margin
  initial
  begin
    #3000;
    fails++;
    give_verdict();
  end
endmodule // iam_mapper_tb
